// ===== core/etcp_timer.sv
// Enhanced timer top: 10-bit counter, comparators A, B, P and both channels.
// Assumes control inputs come from logic on i_mclk and stay static while
// the timer runs; changing them mid-run gives undefined waveforms.
// Notes on behaviour
// - Both mode fields zero selects compare-match output mode.
// - Clear-select low clears on P match or overflow; flags A, B and P.
// - Clear-select high clears on A match; flags A and B, never P.
// - Pins change only on A or B compare match, never on P.
// - On match each pin goes high, low or toggles per its action field.
// - Compare action codes: 00 hold, 01 low, 10 high, 11 toggle.
// - Enable rising edge loads each pin with its initial level.
// - Mode 11 counts and flags like compare mode, pins undriven.
// - Exchange bit picks which register sets period and which duty in edge PWM.
// - PWM sets separate flags on comparator A and P matches.
// - PWM action field enables waveform or forces inactive or active.
// - Polarity bit inverts; output-control bit picks active level.
// - Alignment 00 edge, 01 up, 10 down, 11 both directions.
// - Edge PWM period is code times 128, code zero gives 1024.
// - Duty at or above the period holds the output active.
// - Edge PWM with clear-select high uses A as period, B only.
// - Centre PWM codes give 256 to 1024, zero 2046; duty 2C-1.
// - Centre PWM with clear-select high: setting 1023 gives 2046.
`timescale 1ns/1ps
module etcp_timer (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_timer_run_enable,
	input wire logic i_chan_a_mode_sel_hi,
	input wire logic i_chan_a_mode_sel_lo,
	input wire logic i_chan_b_mode_sel_hi,
	input wire logic i_chan_b_mode_sel_lo,
	input wire logic i_chan_a_action_hi,
	input wire logic i_chan_a_action_lo,
	input wire logic i_chan_b_action_hi,
	input wire logic i_chan_b_action_lo,
	input wire logic i_chan_a_initial_level,
	input wire logic i_chan_b_initial_level,
	input wire logic i_chan_a_output_invert,
	input wire logic i_chan_b_output_invert,
	input wire logic i_counter_clear_select,
	input wire logic i_duty_period_exchange,
	input wire logic i_pwm_align_sel_hi,
	input wire logic i_pwm_align_sel_lo,
	input wire logic [etcp_pkg::CNT_W-1:0] i_compare_a_value,
	input wire logic [etcp_pkg::CNT_W-1:0] i_compare_b_value,
	input wire logic [etcp_pkg::CODE_W-1:0] i_period_value,
	output logic [etcp_pkg::CNT_W-1:0] o_counter,
	output logic o_compare_a_flag,
	output logic o_compare_b_flag,
	output logic o_period_match_flag,
	output logic o_chan_a_out_pin,
	output logic o_chan_a_out_oe,
	output logic o_chan_b_out_pin0,
	output logic o_chan_b_out_pin1,
	output logic o_chan_b_out_pin2,
	output logic o_chan_b_out_oe0,
	output logic o_chan_b_out_oe1,
	output logic o_chan_b_out_oe2
);
	import etcp_pkg::*;

	logic [CNT_W-1:0] cnt;
	logic down;
	logic run_q;
	logic [CNT_W-1:0] next_cnt;
	logic next_down;
	etcp_mode_t mode_a;
	etcp_mode_t mode_b;
	logic legal, cmp_like, pwm, centre, run, rise, cclr;
	logic [1:0] align;
	logic [CNT_W-1:0] code10, p_top, c_top;
	logic [PER_W-1:0] plen, duty_a, duty_b, cnt11;
	logic m_a, m_b, m_p, edge_end, dir_ok;
	logic fa, fb, fp;
	logic act_a, act_b;
	logic b_pin, b_oe;

	assign mode_a = etcp_dec_mode(i_chan_a_mode_sel_hi, i_chan_a_mode_sel_lo);
	assign mode_b = etcp_dec_mode(i_chan_b_mode_sel_hi, i_chan_b_mode_sel_lo);
	// Mismatched mode pairs are not permitted, so they simply stop the timer.
	assign legal = (mode_a == mode_b) && (mode_a != MODE_CAP);
	assign cmp_like = legal
		&& (mode_a == MODE_CMP || mode_a == MODE_TMR);
	assign pwm = legal && (mode_a == MODE_PWM);
	assign align = {i_pwm_align_sel_hi, i_pwm_align_sel_lo};
	assign centre = pwm && (align != ALIGN_EDGE);
	assign run = i_timer_run_enable && legal;
	assign rise = i_timer_run_enable && !run_q;
	assign cclr = i_counter_clear_select;
	assign code10 = CNT_W'(i_period_value);
	assign cnt11 = {1'b0, cnt};

	// Comparator P compares against the last count of the code times 128 period.
	always_comb begin
		if (i_period_value == CODE_FULL) begin
			p_top = CNT_TOP;
		end else begin
			p_top = CNT_W'(code10 << EDGE_SHIFT) - CNT_ONE;
		end
	end

	always_comb begin
		duty_a = {1'b0, i_compare_a_value};
		duty_b = {1'b0, i_compare_b_value};
		if (cclr || i_duty_period_exchange) begin
			plen = (i_compare_a_value == CNT_ZERO) ? FULL_PER :
				duty_a;
			if (!cclr) begin
				duty_a = PER_W'(code10 << EDGE_SHIFT);
			end
		end else if (i_period_value == CODE_FULL) begin
			plen = FULL_PER;
		end else begin
			plen = PER_W'(code10 << EDGE_SHIFT);
		end
	end

	// Centre turnaround point; the full period is twice this value.
	always_comb begin
		if (cclr) begin
			c_top = (i_compare_a_value == CNT_ZERO) ? CNT_ONE :
				i_compare_a_value;
		end else if (i_period_value == CODE_FULL) begin
			c_top = CNT_TOP;
		end else begin
			c_top = CNT_W'((code10 + CNT_ONE) << CTR_SHIFT);
		end
	end

	assign m_a = (cnt == i_compare_a_value);
	assign m_b = (cnt == i_compare_b_value);
	assign m_p = (cnt == p_top);
	assign edge_end = (cnt11 == plen - PER_W'(CNT_ONE));

	always_comb begin
		case (align)
			ALIGN_UP: dir_ok = !down;
			ALIGN_DOWN: dir_ok = down;
			ALIGN_BOTH: dir_ok = 1'b1;
			default: dir_ok = 1'b1;
		endcase
	end

	always_comb begin
		fa = 1'b0;
		fb = 1'b0;
		fp = 1'b0;
		if (cmp_like) begin
			fa = m_a;
			fb = m_b;
			fp = !cclr && m_p;
		end else if (centre) begin
			fa = m_a && dir_ok;
			fb = m_b && dir_ok;
			fp = down && (cnt <= CNT_ONE);
		end else if (pwm) begin
			fa = m_a;
			fb = m_b;
			fp = edge_end;
		end
	end

	always_comb begin
		next_cnt = cnt + CNT_ONE;
		next_down = down;
		if (centre) begin
			if (!down) begin
				if (cnt >= c_top) begin
					next_cnt = (c_top <= CNT_ONE) ? CNT_ZERO : c_top - CNT_ONE;
					next_down = (c_top > CNT_ONE);
				end
			end else if (cnt <= CNT_ONE) begin
				next_cnt = CNT_ZERO;
				next_down = 1'b0;
			end else begin
				next_cnt = cnt - CNT_ONE;
			end
		end else if (pwm) begin
			if (edge_end) begin
				next_cnt = CNT_ZERO;
			end
		end else if (cclr ? m_a : m_p) begin
			next_cnt = CNT_ZERO;
		end
	end

	// Duty at or above the period keeps the wave active the whole period.
	always_comb begin
		if (centre) begin
			act_a = (i_compare_a_value >= c_top)
				|| (cnt < i_compare_a_value);
			act_b = (i_compare_b_value >= c_top)
				|| (cnt < i_compare_b_value);
		end else begin
			act_a = (duty_a >= plen) || (cnt11 < duty_a);
			act_b = (duty_b >= plen) || (cnt11 < duty_b);
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_q <= 1'b0;
		end else if (i_clk_en) begin
			run_q <= i_timer_run_enable;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= CNT_ZERO;
			down <= 1'b0;
		end else if (i_clk_en) begin
			if (rise) begin
				cnt <= CNT_ZERO;
				down <= 1'b0;
			end else if (run) begin
				cnt <= next_cnt;
				down <= next_down;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_counter <= CNT_ZERO;
		end else if (i_clk_en) begin
			o_counter <= cnt;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_compare_a_flag <= 1'b0;
			o_compare_b_flag <= 1'b0;
			o_period_match_flag <= 1'b0;
		end else if (i_clk_en) begin
			o_compare_a_flag <= run && !rise && fa;
			o_compare_b_flag <= run && !rise && fb;
			o_period_match_flag <= run && !rise && fp;
		end
	end

	// Channel A is the period source when clear-select is high in PWM.
	etcp_chan u_chan_a (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_load(rise),
		.i_init_level(i_chan_a_initial_level),
		.i_match(run && !rise && cmp_like && fa),
		.i_action({i_chan_a_action_hi, i_chan_a_action_lo}),
		.i_pwm_mode(pwm),
		.i_pwm_active(act_a),
		.i_invert(i_chan_a_output_invert),
		.i_drive((legal && mode_a == MODE_CMP) || (pwm && !cclr)),
		.o_pin(o_chan_a_out_pin),
		.o_oe(o_chan_a_out_oe)
	);

	etcp_chan u_chan_b (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_load(rise),
		.i_init_level(i_chan_b_initial_level),
		.i_match(run && !rise && cmp_like && fb),
		.i_action({i_chan_b_action_hi, i_chan_b_action_lo}),
		.i_pwm_mode(pwm),
		.i_pwm_active(act_b),
		.i_invert(i_chan_b_output_invert),
		.i_drive((legal && mode_a == MODE_CMP) || pwm),
		.o_pin(b_pin),
		.o_oe(b_oe)
	);

	assign o_chan_b_out_pin0 = b_pin;
	assign o_chan_b_out_pin1 = b_pin;
	assign o_chan_b_out_pin2 = b_pin;
	assign o_chan_b_out_oe0 = b_oe;
	assign o_chan_b_out_oe1 = b_oe;
	assign o_chan_b_out_oe2 = b_oe;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	a_p_clear_count: assert property (i_clk_en && run && !rise && cmp_like
		&& !cclr && m_p |=> cnt == CNT_ZERO)
		else $error("counter not cleared on P match");
	a_a_clear_count: assert property (i_clk_en && run && !rise && cmp_like
		&& cclr && m_a |=> cnt == CNT_ZERO && o_compare_a_flag)
		else $error("counter not cleared on A match");
	a_no_p_flag: assert property (i_clk_en && cmp_like && cclr
		|=> !o_period_match_flag)
		else $error("period flag set with clear-select high");
	a_a_flag_match: assert property (i_clk_en && run && !rise && cmp_like
		&& m_a |=> o_compare_a_flag)
		else $error("A flag missing on match");
	a_init_level: assert property (i_clk_en && rise && legal
		&& mode_a == MODE_CMP |=> o_chan_a_out_pin ==
		$past(i_chan_a_initial_level ^ i_chan_a_output_invert))
		else $error("pin not loaded with initial level");
	a_drive_low: assert property (i_clk_en && run && !rise && cmp_like
		&& m_a && {i_chan_a_action_hi, i_chan_a_action_lo} == ACT_LOW
		|=> o_chan_a_out_pin == $past(i_chan_a_output_invert))
		else $error("drive-low action failed");
	a_tmr_undriven: assert property (i_clk_en && legal && mode_a == MODE_TMR
		|=> !o_chan_a_out_oe && !o_chan_b_out_oe0)
		else $error("pin driven in timer mode");
	a_edge_wrap: assert property (i_clk_en && run && !rise && pwm && !centre
		&& edge_end |=> cnt == CNT_ZERO && o_period_match_flag)
		else $error("edge period end missed");
	a_full_duty: assert property (i_clk_en && pwm && !centre
		&& duty_b >= plen && {i_chan_b_action_hi, i_chan_b_action_lo}
		== PWM_WAVE |=> o_chan_b_out_pin0 ==
		$past(i_chan_b_initial_level ^ i_chan_b_output_invert))
		else $error("full duty not held active");
	a_centre_turn: assert property (i_clk_en && run && !rise && centre
		&& !down && cnt >= c_top && c_top > CNT_ONE |=> down)
		else $error("centre count did not turn down");

	c_cmp_match: cover property (run && cmp_like && m_a && i_clk_en);
	c_edge_pwm: cover property (pwm && !centre && edge_end && run);
	c_centre_bottom: cover property (centre && run && fp);
	c_tmr_flag: cover property (mode_a == MODE_TMR && o_compare_b_flag);

endmodule : etcp_timer

// ===== core/etcp_pkg.sv
// Shared constants, mode type and mode decoder for the enhanced timer.
// Assumes one timer clock and control bits that are static while running.
package etcp_pkg;

	localparam int CNT_W = 10;
	localparam int PER_W = 11;
	localparam int CODE_W = 3;
	localparam int EDGE_SHIFT = 7;
	localparam int CTR_SHIFT = 6;

	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	localparam logic [1:0] PWM_INACT = 2'h0;
	localparam logic [1:0] PWM_ACT = 2'h1;
	localparam logic [1:0] PWM_WAVE = 2'h2;

	localparam logic [1:0] ALIGN_EDGE = 2'h0;
	localparam logic [1:0] ALIGN_UP = 2'h1;
	localparam logic [1:0] ALIGN_DOWN = 2'h2;
	localparam logic [1:0] ALIGN_BOTH = 2'h3;

	localparam logic [PER_W-1:0] FULL_PER = 11'h400;
	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
	localparam logic [CNT_W-1:0] CNT_TOP = 10'h3ff;
	localparam logic [CODE_W-1:0] CODE_FULL = 3'h0;

	typedef enum logic [1:0] {
		MODE_CMP,
		MODE_CAP,
		MODE_PWM,
		MODE_TMR
	} etcp_mode_t;

	function automatic etcp_mode_t etcp_dec_mode(input logic hi,
		input logic lo);
		case ({hi, lo})
			2'h0: return MODE_CMP;
			2'h1: return MODE_CAP;
			2'h2: return MODE_PWM;
			default: return MODE_TMR;
		endcase
	endfunction : etcp_dec_mode

endpackage : etcp_pkg

// ===== core/etcp_chan.sv
// One output channel: compare-mode level state and the registered pin.
// Assumes the parent supplies match, load and PWM level on the same clock.
`timescale 1ns/1ps
module etcp_chan (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_load,
	input wire logic i_init_level,
	input wire logic i_match,
	input wire logic [1:0] i_action,
	input wire logic i_pwm_mode,
	input wire logic i_pwm_active,
	input wire logic i_invert,
	input wire logic i_drive,
	output logic o_pin,
	output logic o_oe
);
	import etcp_pkg::*;

	logic level;
	logic next_level;
	logic pwm_on;
	logic next_pin;

	always_comb begin
		next_level = level;
		if (i_load) begin
			next_level = i_init_level;
		end else if (i_match && !i_pwm_mode) begin
			case (i_action)
				ACT_LOW: next_level = 1'b0;
				ACT_HIGH: next_level = 1'b1;
				ACT_TOGGLE: next_level = ~level;
				default: next_level = level;
			endcase
		end
	end

	// Single pulse is not built here, so that code parks the pin inactive.
	always_comb begin
		case (i_action)
			PWM_ACT: pwm_on = 1'b1;
			PWM_WAVE: pwm_on = i_pwm_active;
			default: pwm_on = 1'b0;
		endcase
	end

	always_comb begin
		if (i_pwm_mode) begin
			next_pin = (pwm_on ? i_init_level : ~i_init_level)
				^ i_invert;
		end else begin
			next_pin = next_level ^ i_invert;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level <= 1'b0;
		end else if (i_clk_en) begin
			level <= next_level;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pin <= 1'b0;
			o_oe <= 1'b0;
		end else if (i_clk_en) begin
			o_pin <= next_pin;
			o_oe <= i_drive;
		end
	end

endmodule : etcp_chan

// ===== verification/etcp_load.sv
// Pin load model: the lines that the timer pins drive, with pull-downs.
// Assumes pin and enable come straight from the timer outputs.
`timescale 1ns/1ps
module etcp_load (
	input wire logic i_pin_a,
	input wire logic i_oe_a,
	input wire logic [2:0] i_pin_b,
	input wire logic [2:0] i_oe_b,
	output logic o_line_a,
	output logic [2:0] o_line_b
);
	// A released line falls to its pull-down and never keeps a stale level.
	assign o_line_a = i_oe_a ? i_pin_a : 1'b0;
	assign o_line_b = i_pin_b & i_oe_b;
endmodule : etcp_load

// ===== verification/testbench.sv
// Self-checking bench for the enhanced timer and its pin load.
// Assumes controls change only while the run bit is low.
`timescale 1ns/1ps
module testbench;
	import etcp_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic en = 1'b1;
	logic run = 1'b0;
	logic inv = 1'b0;
	logic ccs = 1'b0;
	logic dpx = 1'b0;
	logic init_a = 1'b0;
	logic init_b = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [1:0] act_a = 2'h0;
	logic [1:0] act_b = 2'h0;
	logic [1:0] align = 2'h0;
	logic [9:0] cmp_a = 10'h000;
	logic [9:0] cmp_b = 10'h000;
	logic [2:0] code = 3'h0;
	logic fa, fb, fp, pa, oea, la;
	logic [2:0] pb, oeb, lb;
	logic [9:0] cnt_o;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	int na, nb, np, ha, hb, bad, per, t, c, da, db, lv;
	etcp_timer i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_clk_en(en),
		.i_timer_run_enable(run), .i_chan_a_mode_sel_hi(mode[1]),
		.i_chan_a_mode_sel_lo(mode[0]), .i_chan_b_mode_sel_hi(mode[1]),
		.i_chan_b_mode_sel_lo(mode[0]), .i_chan_a_action_hi(act_a[1]),
		.i_chan_a_action_lo(act_a[0]), .i_chan_b_action_hi(act_b[1]),
		.i_chan_b_action_lo(act_b[0]), .i_chan_a_initial_level(init_a),
		.i_chan_b_initial_level(init_b), .i_chan_a_output_invert(inv),
		.i_chan_b_output_invert(inv), .i_counter_clear_select(ccs),
		.i_duty_period_exchange(dpx), .i_pwm_align_sel_hi(align[1]),
		.i_pwm_align_sel_lo(align[0]), .i_compare_a_value(cmp_a),
		.i_compare_b_value(cmp_b), .i_period_value(code), .o_counter(cnt_o),
		.o_compare_a_flag(fa), .o_compare_b_flag(fb),
		.o_period_match_flag(fp), .o_chan_a_out_pin(pa),
		.o_chan_a_out_oe(oea), .o_chan_b_out_pin0(pb[0]),
		.o_chan_b_out_pin1(pb[1]), .o_chan_b_out_pin2(pb[2]),
		.o_chan_b_out_oe0(oeb[0]), .o_chan_b_out_oe1(oeb[1]),
		.o_chan_b_out_oe2(oeb[2]));
	etcp_load i_load (.i_pin_a(pa), .i_oe_a(oea), .i_pin_b(pb),
		.i_oe_b(oeb), .o_line_a(la), .o_line_b(lb));
	always #25 i_mclk = ~i_mclk;
	task automatic complete_run();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	// The ceiling sits well above the longest run of all scenarios.
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic chk_n(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			miscompares++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk_n
	task automatic chk_b(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk_b
	function automatic logic exp_cmp(input logic [1:0] a, input logic i);
		case (a)
			2'h0: return i;
			2'h1: return 1'b0;
			2'h2: return 1'b1;
			default: return ~i;
		endcase
	endfunction : exp_cmp
	function automatic int hi_cnt(input int d, input int p, input int l);
		int act;
		act = (d >= p) ? p : d;
		return (l == 1 || l == 2) ? act : p - act;
	endfunction : hi_cnt
	task automatic stop();
		@(posedge i_mclk);
		run <= 1'b0;
		@(posedge i_mclk);
	endtask : stop
	task automatic go();
		repeat (2) @(posedge i_mclk);
		run <= 1'b1;
		repeat (2) @(posedge i_mclk);
		#1;
	endtask : go
	// Any window of one whole period sees every event of it exactly once.
	task automatic measure(input int n);
		na = 0; nb = 0; np = 0; ha = 0; hb = 0; bad = 0;
		repeat (n) begin
			@(posedge i_mclk);
			#1;
			na += (fa === 1'b1);
			nb += (fb === 1'b1);
			np += (fp === 1'b1);
			ha += (la === 1'b1);
			hb += (lb[0] === 1'b1);
			bad += (lb !== {3{lb[0]}});
		end
		chk_n(bad, 0);
	endtask : measure
	initial begin
		void'($urandom(32'hd8df));
		repeat (5) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			for (int k = 0; k < 2; k++) begin
				stop();
				mode <= m ? 2'h3 : 2'h0;
				code <= 3'(k);
				act_a <= ACT_TOGGLE;
				act_b <= ACT_HIGH;
				init_a <= 1'($urandom);
				cmp_a <= 10'($urandom_range(100, 5));
				cmp_b <= 10'($urandom_range(120, 1));
				go();
				chk_b(oea, m == 0);
				if (m == 0) chk_b(la, init_a);
				per = k ? 128 : 1024;
				repeat (per) @(posedge i_mclk);
				measure(2 * per);
				chk_n(np, 2);
				chk_n(na, 2);
				chk_n(nb, 2);
				chk_n(ha, m ? 0 : per);
				chk_n(hb, m ? 0 : 2 * per);
			end
		end
		for (int a = 0; a < 4; a++) begin
			stop();
			mode <= 2'h0;
			code <= 3'h1;
			act_a <= 2'(a);
			act_b <= 2'(3 - a);
			init_a <= 1'($urandom);
			init_b <= 1'($urandom);
			cmp_a <= 10'h00a;
			cmp_b <= 10'h014;
			go();
			repeat (30) @(posedge i_mclk);
			#1;
			chk_b(la, exp_cmp(act_a, init_a));
			chk_b(lb[0], exp_cmp(act_b, init_b));
			chk_n(cnt_o, 30);
			@(posedge i_mclk);
			en <= 1'b0;
			repeat (5) @(posedge i_mclk);
			en <= 1'b1;
			#1;
			chk_n(cnt_o, 31);
		end
		stop();
		ccs <= 1'b1;
		t = $urandom_range(100, 20);
		cmp_a <= 10'(t);
		go();
		measure(5 * (t + 1));
		chk_n(na, 5);
		chk_n(np, 0);
		for (int k = 0; k < 10; k++) begin
			stop();
			c = (k == 0) ? 1 : $urandom_range(7, 0);
			lv = $urandom_range(3, 0);
			da = (k == 0) ? 128 : $urandom_range(1023, 1);
			db = $urandom_range(1023, 1);
			mode <= 2'h2;
			act_a <= PWM_WAVE;
			act_b <= (k == 4) ? PWM_INACT : (k == 5) ? PWM_ACT : PWM_WAVE;
			align <= (k < 6) ? ALIGN_EDGE : 2'((k - 6) % 3 + 1);
			ccs <= 1'b0;
			dpx <= (k == 3);
			code <= 3'(c);
			cmp_a <= 10'(da);
			cmp_b <= 10'(db);
			init_a <= lv[0];
			init_b <= lv[0];
			inv <= lv[1];
			if (k == 4) db = 0;
			if (k == 5) db = 1024;
			go();
			if (k < 6) begin
				per = (k == 3) ? da : c ? c * 128 : 1024;
				repeat (per) @(posedge i_mclk);
				measure(per);
				chk_n(ha, hi_cnt(k == 3 ? c * 128 : da, per,
					lv));
				chk_n(hb, hi_cnt(db, per, lv));
				chk_n(np, 1);
				chk_n(na, da < per);
			end else begin
				t = c ? (c + 1) * 64 : 1023;
				per = 2 * t;
				repeat (per) @(posedge i_mclk);
				measure(per);
				chk_n(ha, hi_cnt(da >= t ? per : 2 * da - 1, per, lv));
				chk_n(hb, hi_cnt(db >= t ? per : 2 * db - 1, per, lv));
			end
		end
		for (int j = 0; j < 2; j++) begin
			stop();
			t = j ? 1023 : $urandom_range(300, 50);
			per = j ? 2046 : t;
			db = $urandom_range(t + (j ? 0 : 4), 1);
			ccs <= 1'b1;
			align <= j ? ALIGN_BOTH : ALIGN_EDGE;
			act_b <= PWM_WAVE;
			cmp_a <= 10'(t);
			cmp_b <= 10'(db);
			init_b <= 1'b1;
			inv <= 1'b0;
			go();
			repeat (per) @(posedge i_mclk);
			measure(per);
			if (j) chk_n(hb, db >= t ? per : 2 * db - 1);
			else chk_n(hb, db >= t ? t : db);
			chk_b(oea, 1'b0);
		end
		complete_run();
	end
endmodule : testbench
